/* cdc_pkg.sv */
package cdc_pkg;
  // ----------------------------------------
  // register map, word indexes (byte = 4x)
  // ----------------------------------------
  localparam int unsigned REG_W = 9;
  localparam int unsigned A_LSB = 2;
  localparam int unsigned A_MSB = 9;
  localparam logic [7:0] IDX_DAC_IF = 8'h03;
  localparam logic [7:0] IDX_DAC_MUTE = 8'h09;
  localparam logic [7:0] IDX_PWR = 8'h0a;
  localparam logic [7:0] IDX_ADC_IF = 8'h0b;
  localparam logic [7:0] IDX_ADC_MUTE = 8'h0c;
  localparam logic [7:0] IDX_STATUS = 8'h0e;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [8:0] RST_DAC_IF = 9'h000;
  localparam logic [8:0] RST_DAC_MUTE = 9'h000;
  localparam logic [8:0] RST_PWR = 9'h080;
  localparam logic [8:0] RST_ADC_IF = 9'h040;
  localparam logic [8:0] RST_ADC_MUTE = 9'h000;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int unsigned B_PHASE = 6;
  localparam int unsigned B_ZCD = 0;
  localparam int unsigned B_DAC_SOFT_MUTE = 3;
  localparam int unsigned B_DEEMPHASIS_ENABLE = 6;
  localparam int unsigned B_ADC_DIS = 0;
  localparam int unsigned B_DAC_DIS = 1;
  localparam int unsigned B_MPD = 4;
  localparam int unsigned B_MS = 5;
  localparam int unsigned F_RATE = 6;
  localparam int unsigned F_FMT = 0;
  localparam int unsigned F_WL = 2;
  localparam int unsigned B_MUTE_R = 0;
  localparam int unsigned B_MUTE_L = 1;
  localparam int unsigned B_MUTE_ALL = 2;
  localparam int unsigned B_ALRP = 4;
  // ----------------------------------------
  // codes and constants
  // ----------------------------------------
  localparam logic [2:0] RATE_128 = 3'h0;
  localparam logic [2:0] RATE_192 = 3'h1;
  localparam logic [2:0] RATE_256 = 3'h2;
  localparam logic [2:0] RATE_384 = 3'h3;
  localparam logic [2:0] RATE_512 = 3'h4;
  localparam logic [2:0] RATE_768 = 3'h5;
  // master clocks per bit clock, 64 bit clocks per frame
  localparam logic [3:0] DIV_128 = 4'h2;
  localparam logic [3:0] DIV_192 = 4'h3;
  localparam logic [3:0] DIV_256 = 4'h4;
  localparam logic [3:0] DIV_384 = 4'h6;
  localparam logic [3:0] DIV_512 = 4'h8;
  localparam logic [3:0] DIV_768 = 4'hc;
  localparam logic [1:0] FMT_RJ = 2'h0;
  localparam logic [1:0] FMT_DSP = 2'h3;
  localparam logic [1:0] WL_16 = 2'h0;
  localparam logic [1:0] WL_20 = 2'h1;
  localparam logic [1:0] WL_32 = 2'h3;
  localparam logic [23:0] MASK_16 = 24'hffff00;
  localparam logic [23:0] MASK_20 = 24'hfffff0;
  localparam logic [23:0] MASK_FULL = 24'hffffff;
  localparam logic [7:0] GAIN_MAX = 8'hff;
  localparam logic [7:0] GAIN_MIN = 8'h00;
  localparam logic [7:0] GAIN_STEP = 8'h01;
  typedef enum logic [1:0] {SM_OPEN, SM_DOWN, SM_SHUT, SM_UP} cdc_smute_t;
endpackage : cdc_pkg

/* cdc_clkgen.sv */
`timescale 1ns/1ns
// frame and bit clock divider from the master clock
module cdc_clkgen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic enable,
  input wire logic [3:0] div,
  output logic bclk_q,
  output logic lrclk_q
);
  logic [3:0] cyc_q;
  logic [3:0] cyc_d;
  logic [5:0] bit_q;
  logic [5:0] bit_d;
  logic wrap;

  // >= guards against a ratio shrinking mid-period
  assign wrap = (cyc_q >= div - 4'h1);

  // next counter values
  always_comb begin
    cyc_d = wrap ? 4'h0 : cyc_q + 4'h1;
    bit_d = wrap ? bit_q + 6'h01 : bit_q;
  end

  // ------------------------------------
  // divider state
  // ------------------------------------
  // frame aligned bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q <= 4'h0;
      bit_q <= 6'h00;
      bclk_q <= 1'b0;
      lrclk_q <= 1'b0;
    end else if (!enable) begin
      cyc_q <= 4'h0;
      bit_q <= 6'h00;
      bclk_q <= 1'b0;
      lrclk_q <= 1'b0;
    end else begin
      cyc_q <= cyc_d;
      bit_q <= bit_d;
      bclk_q <= (cyc_d >= (div >> 1)); // odd ratios get a long high
      lrclk_q <= bit_d[5];
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_lr_on_low;
    $changed(lrclk_q) |-> !bclk_q;
  endproperty
  a_lr_on_low: assert property (p_lr_on_low) else $error("frame edge off bit low");

  property p_lr_whole;
    (enable && $changed(lrclk_q)) |-> (bit_q[4:0] == 5'h00);
  endproperty
  a_lr_whole: assert property (p_lr_whole) else $error("frame not whole bits");
endmodule : cdc_clkgen

/* cdc_ctrl_regs.sv */
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ns
// Function
// - phase bit inverts dac output
// - volume waits for zero cross unless disabled
// - soft mute ramps gain at filter input
// - routing off, powerdown, zero attenuation mute abruptly
// - adc right, left, both mute bits
// - de-emphasis bit enables dac filter
// - adc disable bit selects low power
// - adc filters held reset while disabled
// - dac disable bit selects low power
// - master power down kills references
// - master select drives frame, bit clocks
// - ratio field sets 256 to 768 fs
// - ratio codes 128, 192 fs dac only
// - adc format field selects serial format
// - adc word length field 16 to 32
// - adc words are signed two's complement
// - dsp mode polarity picks mode a or b
module cdc_ctrl_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [23:0] dac_sample,
  input wire logic dac_sample_valid,
  output logic [23:0] dac_data,
  output logic [7:0] dac_gain,
  output logic dac_hard_mute,
  input wire logic [7:0] vol_target,
  input wire logic vol_update,
  output logic [7:0] vol_applied,
  input wire logic [3:0] dac_output_routing,
  input wire logic powerdown_bit,
  input wire logic atten_zero,
  output logic deemphasis_enable,
  output logic dac_disable,
  output logic adc_disable,
  output logic adc_filter_reset,
  output logic master_power_down,
  input wire logic [23:0] adc_left_in,
  input wire logic [23:0] adc_right_in,
  output logic [31:0] adc_left_word,
  output logic [31:0] adc_right_word,
  output logic [1:0] adc_format_select,
  output logic [1:0] adc_word_length,
  output logic adc_dsp_mode_b,
  input wire logic dac_frame_clock_i,
  output logic dac_frame_clock_o,
  output logic dac_frame_clock_oe_n,
  input wire logic dac_bit_clock_i,
  output logic dac_bit_clock_o,
  output logic dac_bit_clock_oe_n
);
  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [8:0] dac_if_q;
  logic [8:0] dac_mute_q;
  logic [8:0] pwr_q;
  logic [8:0] adc_if_q;
  logic [8:0] adc_mute_q;
  logic [7:0] idx;
  logic hit;
  logic wr_en;
  logic [8:0] rd_mux;
  logic [8:0] status;
  logic dac_master_select;
  logic zero_cross_disable;
  logic dac_soft_mute;
  logic [2:0] dac_clock_ratio;
  logic [3:0] div;
  logic gen_bclk;
  logic gen_lrclk;
  logic [1:0] lr_sync_q;
  logic [1:0] bc_sync_q;
  logic vol_pending_q;
  logic [7:0] vol_target_q;
  logic [7:0] vol_applied_q;
  logic prev_sign_q;
  logic zero_cross;
  cdc_pkg::cdc_smute_t sm_q;
  logic [7:0] gain_q;
  logic hard_mute_q;
  logic [23:0] dac_data_q;
  logic [23:0] wl_mask;
  logic mute_l;
  logic mute_r;
  logic [31:0] adc_l_q;
  logic [31:0] adc_r_q;
  logic [31:0] prdata_q;

  assign idx = paddr[cdc_pkg::A_MSB:cdc_pkg::A_LSB];
  assign hit = (paddr[1:0] == 2'h0) &&
               (idx == cdc_pkg::IDX_DAC_IF || idx == cdc_pkg::IDX_DAC_MUTE ||
                idx == cdc_pkg::IDX_PWR || idx == cdc_pkg::IDX_ADC_IF ||
                idx == cdc_pkg::IDX_ADC_MUTE || idx == cdc_pkg::IDX_STATUS) &&
               (paddr[11:10] == 2'h0);
  // writes land only at the access edge; pready is always high
  assign wr_en = psel && penable && pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // register writes, one word per register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dac_if_q <= cdc_pkg::RST_DAC_IF;
      dac_mute_q <= cdc_pkg::RST_DAC_MUTE;
      pwr_q <= cdc_pkg::RST_PWR;
      adc_if_q <= cdc_pkg::RST_ADC_IF;
      adc_mute_q <= cdc_pkg::RST_ADC_MUTE;
    end else if (wr_en) begin
      case (idx)
        cdc_pkg::IDX_DAC_IF: dac_if_q <= pwdata[8:0];
        cdc_pkg::IDX_DAC_MUTE: dac_mute_q <= pwdata[8:0];
        cdc_pkg::IDX_PWR: pwr_q <= pwdata[8:0];
        cdc_pkg::IDX_ADC_IF: adc_if_q <= pwdata[8:0];
        cdc_pkg::IDX_ADC_MUTE: adc_mute_q <= pwdata[8:0];
        default: ;
      endcase
    end
  end

  // status word shows live block state
  assign status = {vol_pending_q, hard_mute_q, gain_q == cdc_pkg::GAIN_MIN,
                   adc_filter_reset, dac_master_select, lr_sync_q[1], bc_sync_q[1],
                   sm_q == cdc_pkg::SM_SHUT, 1'b0};

  // read mux, reserved bits read zero
  always_comb begin
    case (idx)
      cdc_pkg::IDX_DAC_IF: rd_mux = dac_if_q;
      cdc_pkg::IDX_DAC_MUTE: rd_mux = dac_mute_q;
      cdc_pkg::IDX_PWR: rd_mux = pwr_q;
      cdc_pkg::IDX_ADC_IF: rd_mux = adc_if_q;
      cdc_pkg::IDX_ADC_MUTE: rd_mux = adc_mute_q;
      cdc_pkg::IDX_STATUS: rd_mux = status;
      default: rd_mux = 9'h000;
    endcase
  end

  // read data captured in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable) begin
      prdata_q <= {23'h000000, hit ? rd_mux : 9'h000};
    end
  end
  assign prdata = prdata_q;

  // ----------------------------------------
  // field decode
  // ----------------------------------------
  assign zero_cross_disable = dac_mute_q[cdc_pkg::B_ZCD];
  assign dac_soft_mute = dac_mute_q[cdc_pkg::B_DAC_SOFT_MUTE];
  assign deemphasis_enable = dac_mute_q[cdc_pkg::B_DEEMPHASIS_ENABLE];
  assign adc_disable = pwr_q[cdc_pkg::B_ADC_DIS];
  assign dac_disable = pwr_q[cdc_pkg::B_DAC_DIS];
  assign master_power_down = pwr_q[cdc_pkg::B_MPD];
  // filters held in reset; master down also covers it
  assign adc_filter_reset = adc_disable || master_power_down;
  assign dac_master_select = pwr_q[cdc_pkg::B_MS];
  assign dac_clock_ratio = pwr_q[cdc_pkg::F_RATE +: 3];
  assign adc_format_select = adc_if_q[cdc_pkg::F_FMT +: 2];
  assign adc_word_length = adc_if_q[cdc_pkg::F_WL +: 2];
  assign adc_dsp_mode_b = (adc_format_select == cdc_pkg::FMT_DSP) &&
                          adc_mute_q[cdc_pkg::B_ALRP];

  // ----------------------------------------
  // dac frame and bit clocks
  // ----------------------------------------
  // ratio to divider
  always_comb begin
    case (dac_clock_ratio)
      cdc_pkg::RATE_128: div = cdc_pkg::DIV_128;
      cdc_pkg::RATE_192: div = cdc_pkg::DIV_192;
      cdc_pkg::RATE_256: div = cdc_pkg::DIV_256;
      cdc_pkg::RATE_384: div = cdc_pkg::DIV_384;
      cdc_pkg::RATE_512: div = cdc_pkg::DIV_512;
      cdc_pkg::RATE_768: div = cdc_pkg::DIV_768;
      default: div = cdc_pkg::DIV_256; // undefined codes fall back to reset rate
    endcase
  end

  cdc_clkgen u_clkgen (
    .pclk(pclk),
    .presetn(presetn),
    .enable(dac_master_select),
    .div(div),
    .bclk_q(gen_bclk),
    .lrclk_q(gen_lrclk)
  );

  assign dac_frame_clock_o = gen_lrclk;
  assign dac_bit_clock_o = gen_bclk;
  assign dac_frame_clock_oe_n = !dac_master_select;
  assign dac_bit_clock_oe_n = !dac_master_select;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lr_sync_q <= 2'h0;
      bc_sync_q <= 2'h0;
    end else begin
      lr_sync_q <= {lr_sync_q[0], dac_frame_clock_i};
      bc_sync_q <= {bc_sync_q[0], dac_bit_clock_i};
    end
  end

  // ----------------------------------------
  // volume with zero-cross gating
  // ----------------------------------------
  assign zero_cross = dac_sample_valid &&
                      ((dac_sample[23] != prev_sign_q) || (dac_sample == 24'h000000));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vol_pending_q <= 1'b0;
      vol_target_q <= cdc_pkg::GAIN_MAX;
      vol_applied_q <= cdc_pkg::GAIN_MAX;
      prev_sign_q <= 1'b0;
    end else begin
      if (dac_sample_valid) begin
        prev_sign_q <= dac_sample[23];
      end
      if (vol_update) begin
        vol_target_q <= vol_target;
        vol_pending_q <= 1'b1; // new request wins over an apply
      end else if (vol_pending_q && (zero_cross_disable || zero_cross)) begin
        vol_applied_q <= vol_target_q;
        vol_pending_q <= 1'b0;
      end
    end
  end
  assign vol_applied = vol_applied_q;

  // ----------------------------------------
  // soft mute ramp, one step per sample
  // ----------------------------------------
  // soft mute ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sm_q <= cdc_pkg::SM_OPEN;
      gain_q <= cdc_pkg::GAIN_MAX;
    end else begin
      case (sm_q)
        cdc_pkg::SM_OPEN: begin
          if (dac_soft_mute) sm_q <= cdc_pkg::SM_DOWN;
        end
        cdc_pkg::SM_DOWN: begin
          if (!dac_soft_mute) begin
            sm_q <= cdc_pkg::SM_UP;
          end else if (gain_q == cdc_pkg::GAIN_MIN) begin
            sm_q <= cdc_pkg::SM_SHUT;
          end else if (dac_sample_valid) begin
            gain_q <= gain_q - cdc_pkg::GAIN_STEP;
          end
        end
        cdc_pkg::SM_SHUT: begin
          if (!dac_soft_mute) sm_q <= cdc_pkg::SM_UP;
        end
        cdc_pkg::SM_UP: begin
          if (dac_soft_mute) begin
            sm_q <= cdc_pkg::SM_DOWN;
          end else if (gain_q == cdc_pkg::GAIN_MAX) begin
            sm_q <= cdc_pkg::SM_OPEN;
          end else if (dac_sample_valid) begin
            gain_q <= gain_q + cdc_pkg::GAIN_STEP;
          end
        end
        default: sm_q <= cdc_pkg::SM_OPEN;
      endcase
    end
  end
  assign dac_gain = gain_q;

  // ----------------------------------------
  // dac datapath
  // ----------------------------------------
  // abrupt mute, no ramp
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hard_mute_q <= 1'b0;
      dac_data_q <= 24'h000000;
    end else begin
      hard_mute_q <= (dac_output_routing == 4'h0) || powerdown_bit || atten_zero;
      if ((dac_output_routing == 4'h0) || powerdown_bit || atten_zero) begin
        dac_data_q <= 24'h000000;
      end else if (dac_sample_valid) begin
        dac_data_q <= dac_if_q[cdc_pkg::B_PHASE] ? 24'h000000 - dac_sample : dac_sample;
      end
    end
  end
  assign dac_hard_mute = hard_mute_q;
  assign dac_data = dac_data_q;

  // ----------------------------------------
  // adc words, signed and left aligned
  // ----------------------------------------
  always_comb begin
    case (adc_word_length)
      cdc_pkg::WL_16: wl_mask = cdc_pkg::MASK_16;
      cdc_pkg::WL_20: wl_mask = cdc_pkg::MASK_20;
      default: wl_mask = cdc_pkg::MASK_FULL;
    endcase
  end

  assign mute_r = adc_mute_q[cdc_pkg::B_MUTE_R] || adc_mute_q[cdc_pkg::B_MUTE_ALL];
  assign mute_l = adc_mute_q[cdc_pkg::B_MUTE_L] || adc_mute_q[cdc_pkg::B_MUTE_ALL];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      adc_l_q <= 32'h0000_0000;
      adc_r_q <= 32'h0000_0000;
    end else begin
      adc_l_q <= (mute_l || adc_filter_reset) ? 32'h0000_0000
                                              : {adc_left_in & wl_mask, 8'h00};
      adc_r_q <= (mute_r || adc_filter_reset) ? 32'h0000_0000
                                              : {adc_right_in & wl_mask, 8'h00};
    end
  end
  assign adc_left_word = adc_l_q;
  assign adc_right_word = adc_r_q;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_phase;
    (dac_sample_valid && !(dac_output_routing == 4'h0) && !powerdown_bit && !atten_zero)
      |=> dac_data == ($past(dac_if_q[cdc_pkg::B_PHASE]) ? 24'h000000 - $past(dac_sample)
                                                         : $past(dac_sample));
  endproperty
  a_phase: assert property (p_phase) else $error("dac phase wrong");

  sequence s_vol_wait;
    vol_pending_q && !vol_update && !zero_cross_disable && !zero_cross;
  endsequence
  property p_zcd_hold;
    s_vol_wait |=> $stable(vol_applied);
  endproperty
  a_zcd_hold: assert property (p_zcd_hold) else $error("volume moved early");

  property p_zcd_off;
    (vol_pending_q && !vol_update && zero_cross_disable) |=> vol_applied == $past(vol_target_q);
  endproperty
  a_zcd_off: assert property (p_zcd_off) else $error("volume not immediate");

  property p_smute_step;
    (sm_q == cdc_pkg::SM_DOWN && dac_soft_mute && dac_sample_valid &&
     gain_q != cdc_pkg::GAIN_MIN) |=> gain_q == $past(gain_q) - cdc_pkg::GAIN_STEP;
  endproperty
  a_smute_step: assert property (p_smute_step) else $error("soft mute step");

  property p_hard;
    (powerdown_bit || atten_zero || dac_output_routing == 4'h0)
      |=> dac_data == 24'h000000 && dac_hard_mute;
  endproperty
  a_hard: assert property (p_hard) else $error("abrupt mute late");

  property p_adc_mute;
    adc_mute_q[cdc_pkg::B_MUTE_ALL] |=> adc_left_word == 32'h0 && adc_right_word == 32'h0;
  endproperty
  a_adc_mute: assert property (p_adc_mute) else $error("adc mute failed");

  property p_filt_rst;
    adc_disable |-> adc_filter_reset ##1 (adc_left_word == 32'h0);
  endproperty
  a_filt_rst: assert property (p_filt_rst) else $error("filters not held");

  property p_master_drive;
    dac_master_select |-> !dac_frame_clock_oe_n && !dac_bit_clock_oe_n;
  endproperty
  a_master_drive: assert property (p_master_drive) else $error("clocks not driven");

  property p_div;
    dac_clock_ratio == cdc_pkg::RATE_192 |-> div == cdc_pkg::DIV_192;
  endproperty
  a_div: assert property (p_div) else $error("192 fs divider");

  property p_signed;
    (!mute_l && !adc_filter_reset) |=> adc_left_word[31] == $past(adc_left_in[23]);
  endproperty
  a_signed: assert property (p_signed) else $error("adc sign lost");

  property p_dsp_b;
    adc_dsp_mode_b |-> adc_format_select == cdc_pkg::FMT_DSP;
  endproperty
  a_dsp_b: assert property (p_dsp_b) else $error("dsp b outside dsp");
endmodule : cdc_ctrl_regs

/* cdc_host_src.sv */
`timescale 1ns/1ns
// ----------------------------------------
// host side serial clock source
// ----------------------------------------
module cdc_host_src (
  input wire logic clk,
  input wire logic run,
  input wire logic [3:0] half,
  output logic bclk,
  output logic lrclk
);
  int cnt = 0;
  int nb = 0;
  initial bclk = 1'b0;
  initial lrclk = 1'b0;
  // host drives clocks
  // bit clock runs without pause between frames while run is high and is held low while run is low
  always @(posedge clk) begin
    if (!run) begin
      cnt <= 0;
      bclk <= 1'b0;
    end else if (cnt + 1 >= half) begin
      cnt <= 0;
      bclk <= ~bclk;
      if (bclk) begin
        nb <= (nb == 31) ? 0 : nb + 1;
        if (nb == 31) lrclk <= ~lrclk;
      end
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule : cdc_host_src

/* codec_dac_adc_control_regs_tb.sv */
`timescale 1ns/1ns
module codec_dac_adc_control_regs_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, aw_l, aw_r, s;
  logic pready, pslverr, hm, dee, ddis, adis, afr, mpd, dspb, bco, bcn, lro, lrn, hb, hl, hrun;
  logic [23:0] ds = 24'h0, dd, al = 24'h0, ar = 24'h0, mk;
  logic dv = 1'b0, vu = 1'b0, pdb = 1'b0, az = 1'b0;
  logic [7:0] gain, vt = 8'h00, va;
  logic [3:0] rt = 4'h9, hh = 4'h2;
  logic [1:0] fs, wls;
  logic [32:0] expq[$];
  int num_errors = 0, tests_run = 0, n;
  int dv_t[6] = '{2, 3, 4, 6, 8, 12};
  logic [7:0] ia[5] = '{8'h03, 8'h09, 8'h0a, 8'h0b, 8'h0c};
  logic [8:0] ra[5];
  wire bc = bcn ? hb : bco;
  wire lr = lrn ? hl : lro;
  always #10 pclk = ~pclk;
  cdc_ctrl_regs cdc_ctrl_regs_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .dac_sample(ds), .dac_sample_valid(dv),
    .dac_data(dd), .dac_gain(gain), .dac_hard_mute(hm), .vol_target(vt), .vol_update(vu),
    .vol_applied(va), .dac_output_routing(rt), .powerdown_bit(pdb), .atten_zero(az),
    .deemphasis_enable(dee), .dac_disable(ddis), .adc_disable(adis),
    .adc_filter_reset(afr), .master_power_down(mpd), .adc_left_in(al), .adc_right_in(ar),
    .adc_left_word(aw_l), .adc_right_word(aw_r), .adc_format_select(fs),
    .adc_word_length(wls), .adc_dsp_mode_b(dspb), .dac_frame_clock_i(lr),
    .dac_frame_clock_o(lro), .dac_frame_clock_oe_n(lrn), .dac_bit_clock_i(bc),
    .dac_bit_clock_o(bco), .dac_bit_clock_oe_n(bcn));
  cdc_host_src cdc_host_src_inst (.clk(pclk), .run(hrun), .half(hh), .bclk(hb), .lrclk(hl));
  initial hrun = 1'b1;
  function automatic logic [31:0] rnd();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : rnd
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  // apb master: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] i, input logic [8:0] d,
                     input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, i, 2'h0};
    pwdata <= {23'h0, d};
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    if (!w) expq.push_back(e);
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] i, input logic [8:0] d);
    apb(1'b1, i, d, 33'h0);
  endtask : wr
  task automatic smp(input logic [23:0] v);
    @(posedge pclk);
    ds <= v;
    dv <= 1'b1;
    @(posedge pclk);
    dv <= 1'b0;
  endtask : smp
  task automatic wt(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask : wt
  // rise-to-rise span of bit clock (f=0) or frame clock (f=1) in pclk cycles
  task automatic gap(input bit f, output int m);
    logic p, c;
    int k;
    m = 0;
    k = 0;
    p = f ? lr : bc;
    while (k < 2) begin
      @(posedge pclk);
      #1;
      c = f ? lr : bc;
      if (c && !p) k++;
      if (k == 1) m++;
      p = c;
    end
  endtask : gap
  // read monitor: oldest note against {pslverr, prdata}
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && expq.size() > 0)
      chk({pslverr, prdata}, expq.pop_front());
  end
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    print_verdict();
  end
  initial begin
    s = 32'h9bfa0e4f;
    ra = '{cdc_pkg::RST_DAC_IF, cdc_pkg::RST_DAC_MUTE, cdc_pkg::RST_PWR,
           cdc_pkg::RST_ADC_IF, cdc_pkg::RST_ADC_MUTE};
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++) apb(1'b0, ia[i], 9'h0, {24'h0, ra[i]});
    apb(1'b0, 8'h05, 9'h0, {1'b1, 32'h0});
    for (int i = 0; i < 5; i++) begin
      n = rnd();
      wr(ia[i], n[8:0]);
      apb(1'b0, ia[i], 9'h0, {24'h0, n[8:0]});
    end
    $display("test registers done");
    wr(8'h09, 9'h040);
    wt(1);
    chk(dee, 1'b1);
    // disables first
    // master power down only ever follows adc and dac disable
    for (int k = 0; k < 4; k++) begin
      ra[0] = (k == 0) ? 9'h001 : (k == 1) ? 9'h002 : (k == 2) ? 9'h013 : 9'h000;
      wr(8'h0a, 9'h080 | ra[0]);
      wt(1);
      chk({adis, afr}, {2{ra[0][0]}} | {1'b0, ra[0][4]});
      chk({ddis, mpd}, {ra[0][1], ra[0][4]});
    end
    $display("test power done");
    // format follows word length, 32 bit never right justified
    for (int w = 0; w < 4; w++) begin
      for (int m = 0; m < 8; m++) begin
        wr(8'h0b, 9'h040 | 9'(w * 5));
        wr(8'h0c, 9'h010 | 9'(m));
        n = rnd();
        al <= n[23:0];
        n = rnd();
        ar <= n[23:0];
        wt(3);
        mk = (w == 0) ? cdc_pkg::MASK_16 : (w == 1) ? cdc_pkg::MASK_20 : cdc_pkg::MASK_FULL;
        chk(aw_l, (m[1] | m[2]) ? 32'h0 : {al & mk, 8'h00});
        chk(aw_r, (m[0] | m[2]) ? 32'h0 : {ar & mk, 8'h00});
        chk({fs, wls, dspb}, {2'(w), 2'(w), w == 3});
      end
    end
    wr(8'h0a, 9'h081);
    wt(2);
    chk(aw_l, 32'h0);
    wr(8'h0a, 9'h080);
    $display("test adc done");
    for (int k = 0; k < 4; k++) begin
      rt <= (k == 0) ? 4'h0 : 4'h9;
      pdb <= (k == 1);
      az <= (k == 2);
      smp(24'h012345);
      wt(2);
      chk({hm, dd == 24'h0}, {k < 3, k < 3});
    end
    wr(8'h09, 9'h008);
    repeat (5) smp(24'h000100);
    #1;
    chk(gain, 8'hfa);
    wr(8'h09, 9'h000);
    repeat (5) smp(24'h000100);
    #1;
    chk(gain, 8'hff);
    @(posedge pclk);
    vt <= 8'h40;
    vu <= 1'b1;
    @(posedge pclk);
    vu <= 1'b0;
    smp(24'h000200);
    wt(2);
    chk(va, 8'hff);
    smp(24'hfff000);
    wt(2);
    chk(va, 8'h40);
    wr(8'h09, 9'h001);
    @(posedge pclk);
    vt <= 8'h20;
    vu <= 1'b1;
    @(posedge pclk);
    vu <= 1'b0;
    wt(3);
    chk(va, 8'h20);
    $display("test dac done");
    chk({bcn, lrn, bco, lro}, 4'hc);
    hrun <= 1'b0;
    for (int c = 0; c < 6; c++) begin
      wr(8'h0a, 9'h020 | 9'(c << 6));
      gap(1'b0, n);
      gap(1'b0, n);
      chk(n, dv_t[c]);
      gap(1'b1, n);
      gap(1'b1, n);
      chk(n, 64 * dv_t[c]);
      chk({bcn, lrn}, 2'b00);
    end
    $display("test clocks done");
    print_verdict();
  end
endmodule : codec_dac_adc_control_regs_tb
